/* File: logic/lcd_pkg.sv */
`default_nettype none
package lcd_pkg;
    // ------------------------------------------------------------
    // Geometry of the display memory
    // ------------------------------------------------------------
    localparam int        NUM_COLS   = 132;
    localparam int        NUM_PAGES  = 9;
    localparam int        RAM_WORDS  = NUM_COLS * NUM_PAGES;
    localparam logic [7:0] COL_MAX   = 8'h83;   // Last column, 131
    localparam logic [3:0] PAGE_MAX  = 4'h8;    // Indicator page
    localparam logic [3:0] COL_HI_MAX = 4'h8;

    // ------------------------------------------------------------
    // Command codes
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_SEG_NORMAL = 8'ha0;
    localparam logic [7:0] CMD_SEG_REV    = 8'ha1;
    localparam logic [7:0] CMD_BIAS_LO    = 8'ha2;
    localparam logic [7:0] CMD_BIAS_HI    = 8'ha3;
    localparam logic [7:0] CMD_ALL_OFF    = 8'ha4;
    localparam logic [7:0] CMD_ALL_ON     = 8'ha5;
    localparam logic [7:0] CMD_INV_OFF    = 8'ha6;
    localparam logic [7:0] CMD_INV_ON     = 8'ha7;
    localparam logic [7:0] CMD_DISP_OFF   = 8'hae;
    localparam logic [7:0] CMD_DISP_ON    = 8'haf;
    localparam logic [7:0] CMD_RMW        = 8'he0;
    localparam logic [7:0] CMD_RMW_END    = 8'hee;
    localparam logic [7:0] CMD_SOFT_RST   = 8'he2;
    localparam logic [3:0] GRP_COL_LO     = 4'h0;
    localparam logic [3:0] GRP_COL_HI     = 4'h1;
    localparam logic [4:0] GRP_RATIO      = 5'h04;
    localparam logic [4:0] GRP_POWER      = 5'h05;
    localparam logic [1:0] GRP_START      = 2'h1;
    localparam logic [3:0] GRP_PAGE       = 4'hb;
    localparam logic [3:0] GRP_COM        = 4'hc;

    // ------------------------------------------------------------
    // Reset values and status layout
    // ------------------------------------------------------------
    localparam logic [2:0] RATIO_RESET = 3'h0;
    localparam logic [2:0] POWER_RESET = 3'h0;
    localparam logic [5:0] START_RESET = 6'h00;
    localparam logic [7:0] COL_RESET   = 8'h00;
    localparam logic [3:0] PAGE_RESET  = 4'h0;
    localparam logic [3:0] STATUS_LOW  = 4'h0;
    localparam logic [7:0] PIX_ALL_ON  = 8'hff;
    localparam logic [7:0] PIX_BLANK   = 8'h00;
    localparam logic [7:0] PAGE8_MASK  = 8'h01;

    // Decoder sequencing
    typedef enum logic [1:0] {
        LCD_IDLE  = 2'b00,
        LCD_FETCH = 2'b01
    } lcd_state_e;
endpackage
`default_nettype wire

/* File: logic/lcd_serial_rx.sv */
`timescale 1ns/10ps
`default_nettype none
module lcd_serial_rx (
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    input  wire logic       enable_in,
    input  wire logic       cs_n_in,
    input  wire logic       sclk_in,
    input  wire logic       sdi_in,
    input  wire logic       cd_in,
    output logic            byte_valid_out,
    output logic [7:0]      byte_out,
    output logic            byte_cd_out
);
    typedef struct packed {
        logic       sclk_d;
        logic [6:0] shift;
        logic [2:0] count;
        logic       valid;
        logic [7:0] data;
        logic       cd;
    } lcd_ser_s;

    lcd_ser_s st, next_st;

    // ------------------------------------------------------------
    // Shifter, first bit is the byte's top bit
    // ------------------------------------------------------------
    always_comb begin
        next_st        = st;
        next_st.sclk_d = sclk_in;
        next_st.valid  = 1'b0;
        if (cs_n_in || !enable_in) begin
            next_st.count = 3'h0;     // Deselect realigns the byte
        end else if (sclk_in && !st.sclk_d) begin
            next_st.shift = {st.shift[5:0], sdi_in};
            next_st.count = st.count + 3'h1;
            if (st.count == 3'h7) begin
                next_st.data  = {st.shift, sdi_in};
                next_st.cd    = cd_in;
                next_st.valid = 1'b1;
            end
        end
    end

    // State register
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign byte_valid_out = st.valid;
    assign byte_out       = st.data;
    assign byte_cd_out    = st.cd;
endmodule
`default_nettype wire

/* File: logic/lcd_pair_buf.sv */
`timescale 1ns/10ps
`default_nettype none
module lcd_pair_buf #(
    parameter int WIDTH = 10
) (
    input  wire logic             clk_in,
    input  wire logic             rst_n_in,
    input  wire logic             in_valid_in,
    input  wire logic [WIDTH-1:0] in_data_in,
    output logic                  in_ready_out,
    output logic                  out_valid_out,
    output logic [WIDTH-1:0]      out_data_out,
    input  wire logic             out_ready_in
);
    typedef struct packed {
        logic [WIDTH-1:0] head;
        logic [WIDTH-1:0] tail;
        logic [1:0]       count;
        logic             room;
    } lcd_buf_s;

    lcd_buf_s st, next_st;
    logic     push;
    logic     pop;

    // ------------------------------------------------------------
    // Two-entry queue, head is the oldest word
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        push    = in_valid_in && st.room;
        pop     = out_ready_in && (st.count != 2'h0);
        if (pop) begin
            next_st.head = st.tail;
        end
        if (push) begin
            if (next_st.count - 2'(pop) == 2'h0) begin
                next_st.head = in_data_in;
            end else begin
                next_st.tail = in_data_in;
            end
        end
        next_st.count = st.count + 2'(push) - 2'(pop);
        next_st.room  = (next_st.count != 2'h2);
    end

    // State register
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            st <= '{head: '0, tail: '0, count: 2'h0, room: 1'b1};
        end else begin
            st <= next_st;
        end
    end

    assign in_ready_out  = st.room;
    assign out_valid_out = (st.count != 2'h0);
    assign out_data_out  = st.head;

    // Full queue refuses further words
    no_overfill_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (st.count == 2'h2 && !out_ready_in) |=> (st.count == 2'h2 && !in_ready_out))
        else $error("Buffer lost a word while full");
endmodule
`default_nettype wire

/* File: logic/lcd_command_decoder.sv */
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - Data write stores byte (bit 0 only on page 8) at page and column, then column advances one, stopping at 131.
// - Data read returns RAM byte; column advances, stopping at 131, unless read-modify-write.
// - First read after column set is a dummy; host discards it.
// - Serial mode offers no way to read display RAM.
// - A0h normal segment mapping, A1h reversed; column still counts up.
// - A6h lights set bits, A7h lights clear bits; RAM unchanged.
// - A5h forces all pixels on over inversion; A4h restores RAM display.
// - All-on while display is off enters power save instead.
// - A2h selects lower bias set, A3h the higher bias set.
// - E0h enters read-modify-write, saves column; reads then hold column.
// - EEh leaves read-modify-write and restores the saved column.
// - E2h resets line, column, page, COM mode, ratio, rmw; RAM kept.
// - Soft reset leaves power control; only hardware reset clears it.
// - C0h-C7h normal COM scan, C8h-CFh reverse; bit 3 decides.
// - 28h-2Fh load follower, regulator, booster enables from bits 0-2.
// - 20h-27h load the 3-bit regulator resistor ratio.
// - Select line plus strobes classify command/data and read/write.
// - Serial bytes arrive top bit first.
// - Reversed mapping drives segment n from column 131-n.
module lcd_command_decoder
    import lcd_pkg::*;
(
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    input  wire logic       serial_sel_in,
    input  wire logic       chip_sel_n_in,
    input  wire logic       cmd_data_select_in,
    input  wire logic       rd_n_in,
    input  wire logic       wr_n_in,
    input  wire logic [7:0] data_in,
    input  wire logic       sclk_in,
    input  wire logic       sdi_in,
    input  wire logic [7:0] scan_seg_in,
    input  wire logic [3:0] scan_page_in,
    output logic [7:0]      data_out,
    output logic            data_oe_out,
    output logic            host_ready_out,
    output logic [7:0]      scan_pixels_out,
    output logic            seg_reverse_out,
    output logic            display_invert_out,
    output logic            all_on_out,
    output logic            display_on_out,
    output logic            power_save_out,
    output logic            bias_high_out,
    output logic            com_reverse_out,
    output logic [2:0]      power_ctrl_out,
    output logic [2:0]      regulator_resistor_ratio_out,
    output logic [5:0]      start_line_out
);
    import lcd_pkg::*;

    typedef struct packed {
        logic       cs1, cs2, rd1, rd2, rd3, wr1, wr2, wr3;
        logic       cd1, cd2, ser1, ser2, sclk1, sclk2, sdi1, sdi2;
        logic [7:0] d1, d2;
        lcd_state_e state;
        logic [3:0] page;
        logic [7:0] col;
        logic [7:0] col_saved;
        logic       rmw;
        logic       seg_rev, invert, all_on, disp_on, psave, bias_hi, com_rev;
        logic [2:0] power;
        logic [2:0] ratio;
        logic [5:0] start;
        logic [7:0] rlatch;
        logic [7:0] dout;
        logic       doe;
        logic [7:0] pix;
    } lcd_dec_s;

    lcd_dec_s    st, next_st;
    logic [7:0]  ram [RAM_WORDS];
    logic [7:0]  ram_q;
    logic [7:0]  scan_q;
    logic        ram_we;
    logic [10:0] host_addr;
    logic [10:0] scan_addr;
    logic [7:0]  scan_col;
    logic        ser_valid;
    logic [7:0]  ser_byte;
    logic        ser_cd;
    logic        push;
    logic [9:0]  push_word;
    logic        item_valid;
    logic [9:0]  item;
    logic        drain;
    logic        it_rd, it_cd;
    logic [7:0]  it_byte;

    // ------------------------------------------------------------
    // Serial receiver and request queue
    // ------------------------------------------------------------
    lcd_serial_rx u_serial (
        .clk_in         (clk_in),
        .rst_n_in       (rst_n_in),
        .enable_in      (st.ser2),
        .cs_n_in        (st.cs2),
        .sclk_in        (st.sclk2),
        .sdi_in         (st.sdi2),
        .cd_in          (st.cd2),
        .byte_valid_out (ser_valid),
        .byte_out       (ser_byte),
        .byte_cd_out    (ser_cd)
    );

    lcd_pair_buf #(.WIDTH(10)) u_queue (
        .clk_in        (clk_in),
        .rst_n_in      (rst_n_in),
        .in_valid_in   (push),
        .in_data_in    (push_word),
        .in_ready_out  (host_ready_out),
        .out_valid_out (item_valid),
        .out_data_out  (item),
        .out_ready_in  (st.state == LCD_IDLE)
    );

    // Queue word is {read, data select, byte}; strobe edges classify
    always_comb begin
        push      = 1'b0;
        push_word = {1'b0, ser_cd, ser_byte};
        if (st.ser2) begin
            push = ser_valid;
        end else if (!st.cs2 && st.wr2 && !st.wr3) begin
            push      = 1'b1;
            push_word = {1'b0, st.cd2, st.d2};
        end else if (!st.cs2 && !st.rd2 && st.rd3) begin
            push      = 1'b1;
            push_word = {1'b1, st.cd2, 8'h00};
        end
    end

    assign it_rd   = item[9];
    assign it_cd   = item[8];
    assign it_byte = item[7:0];
    assign drain   = item_valid && (st.state == LCD_IDLE);

    // ------------------------------------------------------------
    // Display memory, host port and scan port
    // ------------------------------------------------------------
    assign host_addr = 11'(st.page) * 11'(NUM_COLS) + 11'(st.col);
    assign scan_col  = st.seg_rev ? (COL_MAX - scan_seg_in) : scan_seg_in;
    assign scan_addr = 11'(scan_page_in) * 11'(NUM_COLS) + 11'(scan_col);
    assign ram_we    = drain && !it_rd && it_cd && (st.col <= COL_MAX);

    // RAM write and both read ports
    always_ff @(posedge clk_in) begin
        if (ram_we) begin
            ram[host_addr] <= (st.page == PAGE_MAX) ? (it_byte & PAGE8_MASK) : it_byte;
        end
        ram_q  <= ram[host_addr];
        scan_q <= ram[scan_addr];
    end

    // ------------------------------------------------------------
    // Synchronisers, decode and sequencing
    // ------------------------------------------------------------
    always_comb begin
        next_st       = st;
        next_st.cs1   = chip_sel_n_in;
        next_st.cs2   = st.cs1;
        next_st.rd1   = rd_n_in;
        next_st.rd2   = st.rd1;
        next_st.rd3   = st.rd2;
        next_st.wr1   = wr_n_in;
        next_st.wr2   = st.wr1;
        next_st.wr3   = st.wr2;
        next_st.cd1   = cmd_data_select_in;
        next_st.cd2   = st.cd1;
        next_st.ser1  = serial_sel_in;
        next_st.ser2  = st.ser1;
        next_st.sclk1 = sclk_in;
        next_st.sclk2 = st.sclk1;
        next_st.sdi1  = sdi_in;
        next_st.sdi2  = st.sdi1;
        next_st.d1    = data_in;
        next_st.d2    = st.d1;
        next_st.doe   = !st.cs2 && !st.rd2 && !st.ser2;
        if (st.state == LCD_FETCH) begin
            next_st.rlatch = ram_q;
            if (!st.rmw && st.col < COL_MAX) begin
                next_st.col = st.col + 8'h01;
            end
            next_st.state = LCD_IDLE;
        end else if (drain) begin
            if (it_rd && it_cd) begin
                next_st.dout  = st.rlatch;
                next_st.state = LCD_FETCH;
            end else if (it_rd) begin
                next_st.dout = {!host_ready_out, !st.seg_rev, !st.disp_on, 1'b0, STATUS_LOW};
            end else if (it_cd) begin
                if (st.col < COL_MAX) begin
                    next_st.col = st.col + 8'h01;
                end
            end else begin
                if (it_byte[7:4] == GRP_COL_LO) begin
                    next_st.col = {st.col[7:4], it_byte[3:0]};
                end else if (it_byte[7:4] == GRP_COL_HI && it_byte[3:0] <= COL_HI_MAX) begin
                    next_st.col = {it_byte[3:0], st.col[3:0]};
                end else if (it_byte[7:3] == GRP_RATIO) begin
                    next_st.ratio = it_byte[2:0];
                end else if (it_byte[7:3] == GRP_POWER) begin
                    next_st.power = it_byte[2:0];
                end else if (it_byte[7:6] == GRP_START) begin
                    next_st.start = it_byte[5:0];
                end else if (it_byte[7:4] == GRP_PAGE && it_byte[3:0] <= PAGE_MAX) begin
                    next_st.page = it_byte[3:0];
                end else if (it_byte[7:4] == GRP_COM) begin
                    next_st.com_rev = it_byte[3];
                end else if (it_byte == CMD_SEG_NORMAL || it_byte == CMD_SEG_REV) begin
                    next_st.seg_rev = it_byte[0];
                end else if (it_byte == CMD_BIAS_LO || it_byte == CMD_BIAS_HI) begin
                    next_st.bias_hi = it_byte[0];
                end else if (it_byte == CMD_ALL_OFF || it_byte == CMD_ALL_ON) begin
                    next_st.all_on = it_byte[0];
                end else if (it_byte == CMD_INV_OFF || it_byte == CMD_INV_ON) begin
                    next_st.invert = it_byte[0];
                end else if (it_byte == CMD_DISP_OFF || it_byte == CMD_DISP_ON) begin
                    next_st.disp_on = it_byte[0];
                end else if (it_byte == CMD_RMW) begin
                    next_st.rmw       = 1'b1;
                    next_st.col_saved = st.col;
                end else if (it_byte == CMD_RMW_END) begin
                    if (st.rmw) begin
                        next_st.col = st.col_saved;
                    end
                    next_st.rmw = 1'b0;
                end else if (it_byte == CMD_SOFT_RST) begin
                    next_st.start   = START_RESET;
                    next_st.col     = COL_RESET;
                    next_st.page    = PAGE_RESET;
                    next_st.com_rev = 1'b0;
                    next_st.ratio   = RATIO_RESET;
                    next_st.rmw     = 1'b0;
                end
                // Any other code leaves every field as it was
            end
        end
        next_st.psave = st.all_on && !st.disp_on;
        if (st.psave) begin
            next_st.pix = PIX_BLANK;
        end else if (st.all_on) begin
            next_st.pix = PIX_ALL_ON;
        end else begin
            next_st.pix = st.invert ? ~scan_q : scan_q;
        end
    end

    // State register, hardware reset clears all fields except the chip select and strobe stages, which load high
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            st <= '{cs1: 1'b1, cs2: 1'b1, rd1: 1'b1, rd2: 1'b1, rd3: 1'b1,
                    wr1: 1'b1, wr2: 1'b1, wr3: 1'b1, state: LCD_IDLE,
                    page: PAGE_RESET, col: COL_RESET, power: POWER_RESET,
                    ratio: RATIO_RESET, start: START_RESET, default: '0};
        end else begin
            st <= next_st;
        end
    end

    // Outputs
    assign data_out                     = st.dout;
    assign data_oe_out                  = st.doe;
    assign scan_pixels_out              = st.pix;
    assign seg_reverse_out              = st.seg_rev;
    assign display_invert_out           = st.invert;
    assign all_on_out                   = st.all_on;
    assign display_on_out               = st.disp_on;
    assign power_save_out               = st.psave;
    assign bias_high_out                = st.bias_hi;
    assign com_reverse_out              = st.com_rev;
    assign power_ctrl_out               = st.power;
    assign regulator_resistor_ratio_out = st.ratio;
    assign start_line_out               = st.start;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence data_read_s;
        drain && it_rd && it_cd && !st.rmw && st.col < COL_MAX;
    endsequence
    sequence rmw_read_s;
        drain && it_rd && it_cd && st.rmw;
    endsequence

    write_advance_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (drain && !it_rd && it_cd && st.col < COL_MAX) |=> (st.col == $past(st.col) + 8'h01))
        else $error("Column did not advance after data write");
    read_advance_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        data_read_s |-> ##1 (st.state == LCD_FETCH) ##1 (st.col == $past(st.col, 2) + 8'h01))
        else $error("Column did not advance after data read");
    rmw_hold_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        rmw_read_s |-> ##2 (st.col == $past(st.col, 2)))
        else $error("Column moved on read in read-modify-write");
    rmw_restore_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (drain && !it_rd && !it_cd && it_byte == CMD_RMW_END && st.rmw)
        |=> (st.col == $past(st.col_saved) && !st.rmw))
        else $error("End did not restore column");
    serial_noread_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (st.ser2 && $past(st.ser2)) |-> !data_oe_out)
        else $error("Data bus driven in serial mode");
    soft_power_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (drain && !it_rd && !it_cd && it_byte == CMD_SOFT_RST)
        |=> ($stable(power_ctrl_out) && st.col == COL_RESET))
        else $error("Soft reset disturbed power control");
    com_dir_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (drain && !it_rd && !it_cd && it_byte[7:4] == GRP_COM)
        |=> (com_reverse_out == $past(it_byte[3])))
        else $error("COM direction not taken from bit 3");
    power_save_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (all_on_out && !display_on_out) |=> power_save_out ##1 (scan_pixels_out == PIX_BLANK))
        else $error("All-on with display off did not save power");
    seg_select_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (drain && !it_rd && !it_cd && it_byte == CMD_SEG_REV) |=> seg_reverse_out)
        else $error("Reverse segment mapping not selected");
endmodule
`default_nettype wire

/* File: bench/lcd_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
module lcd_host_model (
    input  wire logic       clk_in,
    input  wire logic       ready_in,
    input  wire logic [7:0] rdata_in,
    output logic            cs_n_out,
    output logic            cd_out,
    output logic            rd_n_out,
    output logic            wr_n_out,
    output logic [7:0]      wdata_out,
    output logic            sclk_out,
    output logic            sdi_out
);
    // Idle bus, strobes high
    initial begin
        {cs_n_out, rd_n_out, wr_n_out} = 3'h7;
        {cd_out, sclk_out, sdi_out} = 3'h0;
        wdata_out = 8'h00;
    end
    // Pins move 1 ns after the clock edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask
    // Parallel write; data kept past the strobe, then scrambled
    task automatic wr(input logic cd, input logic [7:0] d);
        while (ready_in !== 1'b1) tick(1);
        {cd_out, wdata_out, cs_n_out, wr_n_out} = {cd, d, 2'b00};
        tick(4);
        wr_n_out = 1'b1;
        tick(4);
        {cs_n_out, wdata_out} = {1'b1, ~d};
        tick(2);
    endtask
    // Parallel read; answer taken while strobe still low
    task automatic rd(input logic cd, output logic [7:0] d);
        while (ready_in !== 1'b1) tick(1);
        {cd_out, cs_n_out, rd_n_out} = {cd, 2'b00};
        tick(8);
        d = rdata_in;
        rd_n_out = 1'b1;
        tick(4);
        cs_n_out = 1'b1;
        tick(2);
    endtask
    // Serial byte, top bit first, clock idles low
    task automatic sw(input logic cd, input logic [7:0] d);
        {cs_n_out, cd_out} = {1'b0, cd};
        for (int i = 7; i >= 0; i--) begin
            sdi_out = d[i];
            tick(4);
            sclk_out = 1'b1;
            tick(4);
            sclk_out = 1'b0;
        end
        tick(2);
        {cs_n_out, sdi_out} = {1'b1, ~d[0]};
        tick(4);
    endtask
endmodule
`default_nettype wire

/* File: bench/test_lcd_command_decoder.sv */
`timescale 1ns/10ps
`default_nettype none
module test_lcd_command_decoder;
    import lcd_pkg::*;
    logic       clk = 0, rst_n = 0, ser = 0, oe_ser = 0;
    logic       cs_n, cd, rd_n, wr_n, sclk, sdi, oe, rdy, ps;
    logic       srev, inv, allon, don, bias, crev;
    logic [7:0] wd, rdat, pix, b, seg = 8'h00;
    logic [3:0] pg = 4'h0;
    logic [2:0] pwr, ratio;
    logic [5:0] sl;
    logic [7:0] cl [8] = '{8'haf, 8'ha1, 8'ha7, 8'ha3, 8'hc8, 8'h2d, 8'h25, 8'he3};
    int         n_errors = 0, n_checks = 0;
    always #10 clk = ~clk;
    // Bus drive seen during serial mode
    always @(posedge clk) if (ser && oe === 1'b1) oe_ser <= 1'b1;
    lcd_command_decoder lcd_command_decoder_inst (.clk_in(clk), .rst_n_in(rst_n),
        .serial_sel_in(ser), .chip_sel_n_in(cs_n), .cmd_data_select_in(cd), .rd_n_in(rd_n),
        .wr_n_in(wr_n), .data_in(wd), .sclk_in(sclk), .sdi_in(sdi), .scan_seg_in(seg),
        .scan_page_in(pg), .data_out(rdat), .data_oe_out(oe), .host_ready_out(rdy),
        .scan_pixels_out(pix), .seg_reverse_out(srev), .display_invert_out(inv),
        .all_on_out(allon), .display_on_out(don), .power_save_out(ps), .bias_high_out(bias),
        .com_reverse_out(crev), .power_ctrl_out(pwr), .regulator_resistor_ratio_out(ratio),
        .start_line_out(sl));
    lcd_host_model lcd_host_model_inst (.clk_in(clk), .ready_in(rdy), .rdata_in(rdat),
        .cs_n_out(cs_n), .cd_out(cd), .rd_n_out(rd_n), .wr_n_out(wr_n), .wdata_out(wd),
        .sclk_out(sclk), .sdi_out(sdi));
    // Compare one byte
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmd(input logic [7:0] c);
        lcd_host_model_inst.wr(1'b0, c);
    endtask
    task automatic rdc(input logic [7:0] exp);
        lcd_host_model_inst.rd(1'b1, b);
        chk(b, exp);
    endtask
    task automatic final_report;
        $display("checks=%0d errors=%0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Watchdog
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        final_report();
    end
    // Main sequence
    initial begin
        lcd_host_model_inst.tick(12);
        rst_n = 1'b1;
        lcd_host_model_inst.tick(2);
        chk({rdy, oe, pwr}, {2'b10, POWER_RESET});
        foreach (cl[i]) cmd(cl[i]);
        chk({srev, inv, bias, crev, pwr, allon}, 8'hfa);
        chk({4'h0, don, ratio}, 8'h0d);
        cmd(8'h6a);
        chk({2'h0, sl}, 8'h2a);
        cmd(8'hb0);
        cmd(8'h10);
        cmd(8'h05);
        lcd_host_model_inst.wr(1'b1, 8'h3c);
        lcd_host_model_inst.wr(1'b1, 8'ha5);
        cmd(8'h10);
        cmd(8'h05);
        lcd_host_model_inst.rd(1'b1, b);
        rdc(8'h3c);
        rdc(8'ha5);
        cmd(8'h10);
        cmd(8'h05);
        cmd(8'he0);
        lcd_host_model_inst.rd(1'b1, b);
        rdc(8'h3c);
        lcd_host_model_inst.wr(1'b1, 8'h77);
        cmd(8'hee);
        lcd_host_model_inst.rd(1'b1, b);
        rdc(8'h77);
        rdc(8'ha5);
        seg = 8'h7e;
        lcd_host_model_inst.tick(3);
        chk(pix, 8'h88);
        cmd(8'ha5);
        chk(pix, PIX_ALL_ON);
        cmd(8'hae);
        chk({ps, pix[6:0]}, 8'h80);
        lcd_host_model_inst.rd(1'b0, b);
        chk(b, 8'h20);
        cmd(8'haf);
        cmd(8'ha4);
        chk(pix, 8'h88);
        cmd(8'he2);
        chk({srev, crev, pwr, ratio}, 8'ha8);
        chk({2'h0, sl}, {2'h0, START_RESET});
        ser = 1'b1;
        lcd_host_model_inst.tick(4);
        lcd_host_model_inst.sw(1'b0, 8'ha0);
        chk({7'h0, srev}, 8'h00);
        lcd_host_model_inst.rd(1'b1, b);
        chk({7'h0, oe_ser}, 8'h00);
        final_report();
    end
endmodule
`default_nettype wire
